// ### inc/drive_ctl_pkg.sv
// Constants shared by the drive start-up and fault control logic.
`default_nettype none
package drive_ctl_pkg;
    // Register byte offsets on the bus.
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] FAULT_OFS  = 8'h08;
    localparam logic [7:0] COUNT_OFS  = 8'h0c;
    localparam int         ADDR_W     = 8;
    // Control register fields and reset value.
    localparam int         CTRL_EN_BIT    = 0;
    localparam int         CTRL_NOSKIP_BIT = 1;
    localparam logic [1:0] CTRL_RESET     = 2'h1;
    // Fault cause bit positions.
    localparam int FLT_WR_NO_GATE = 0;
    localparam int FLT_NO_AC      = 1;
    localparam int FLT_NO_DC      = 2;
    localparam int FLT_ER_NO_CMD  = 3;
    localparam int FLT_NO_ERASE   = 4;
    localparam int FLT_MULTI_HEAD = 5;
    localparam int FLT_OPEN_COIL  = 6;
    localparam int FLT_W          = 7;
    // Index pulses the start-up wait counter must see.
    localparam logic [7:0] DELAY_REVS = 8'h10;
    localparam int         HEADS      = 4;
    // Start-up sequence states, one-hot.
    typedef enum logic [6:0] {
        ST_LOAD   = 7'h01,
        ST_RUN    = 7'h02,
        ST_CART   = 7'h04,
        ST_SPIN   = 7'h08,
        ST_SEEK   = 7'h10,
        ST_TRACKS = 7'h20,
        ST_READY  = 7'h40
    } seq_e;
endpackage
`default_nettype wire

// ### src/drive_ctl.sv
// Drive start-up sequencer, write/erase supervision and AHB-Lite registers.
`default_nettype none
module drive_ctl (
    input  wire logic        hclk,           // System clock, 200 MHz.
    input  wire logic        hresetn,        // Asynchronous reset, low.
    input  wire logic        hsel,           // AHB slave select.
    input  wire logic [31:0] haddr,          // AHB address.
    input  wire logic [1:0]  htrans,         // AHB transfer type.
    input  wire logic        hwrite,         // AHB write.
    input  wire logic [2:0]  hsize,          // AHB size.
    input  wire logic [31:0] hwdata,         // AHB write data.
    input  wire logic        hready,         // AHB bus ready.
    output logic      [31:0] hrdata,         // AHB read data.
    output logic             hreadyout,      // AHB slave ready.
    output logic             hresp,          // AHB response, OKAY.
    input  wire logic        run_switch,     // Operator switch, high Run.
    input  wire logic        cart_present,   // Cartridge installed.
    input  wire logic        brush_home,     // Brush home sensor.
    input  wire logic        speed_sense,    // Spindle at speed sensor.
    input  wire logic        emerg_withdraw, // Emergency head withdraw.
    input  wire logic        heads_over_data_area, // Heads over tracks.
    input  wire logic        bottom_disk_index,    // Lower disk index.
    input  wire logic        write_gate_n,   // Write enable, low.
    input  wire logic        erase_cmd,      // Erase request, high.
    input  wire logic        wr_cur_ac,      // AC write current seen.
    input  wire logic        wr_cur_dc,      // DC write current seen.
    input  wire logic        erase_cur,      // Erase current seen.
    input  wire logic [3:0]  head_sel,       // Head select lines.
    input  wire logic        coil_open,      // Open head coil seen.
    output logic             phase1_en,      // Spindle phase 1 enable.
    output logic             phase2_en,      // Spindle phase 2 enable.
    output logic             brush_enable,   // Brush motor enable.
    output logic             cartridge_release, // Cartridge unlock.
    output logic             initialize,     // Initialize line.
    output logic             head_withdraw,  // Heads held retracted.
    output logic             positioner_free, // Positioner released.
    output logic             seek_zero,      // Seek to cylinder zero.
    output logic             brushes_parked, // Brushes at home.
    output logic             ready,          // Drive ready to controller.
    output logic             ready_lamp,     // Ready indicator.
    output logic             write_fault_n,  // Write check line, low.
    output logic             check_lamp,     // Write check indicator.
    output logic             write_protect   // Write protect forced.
);
    localparam int NSYNC = 17;

    // Counts how many head select lines are active.
    function automatic logic [2:0] ones4(input logic [3:0] v);
        ones4 = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]}
              + {2'b00, v[3]};
    endfunction

    // Pin inputs pass two flip-flops; inverted pins reset to their idle.
    logic [NSYNC-1:0] meta_q;
    logic [NSYNC-1:0] sync_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= {run_switch, cart_present, ~brush_home, speed_sense,
                       emerg_withdraw, heads_over_data_area,
                       bottom_disk_index, ~write_gate_n, erase_cmd,
                       wr_cur_ac, wr_cur_dc, erase_cur, coil_open,
                       head_sel};
            sync_q <= meta_q;
        end
    end

    logic       s_run, s_cart, s_away, s_speed, s_emerg, s_tracks;
    logic       s_index, s_wgate, s_ecmd, s_ac, s_dc, s_ecur, s_open;
    logic [3:0] s_heads;
    assign {s_run, s_cart, s_away, s_speed, s_emerg, s_tracks, s_index,
            s_wgate, s_ecmd, s_ac, s_dc, s_ecur, s_open} = sync_q[16:4];
    assign s_heads = sync_q[3:0];

    // Edge history of switch and index.
    logic run_d1_q, index_d1_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_d1_q   <= 1'b0;
            index_d1_q <= 1'b0;
        end else begin
            run_d1_q   <= s_run;
            index_d1_q <= s_index;
        end
    end

    logic ctrl_en_q, ctrl_noskip_q, go_run, index_rise;
    assign go_run     = s_run & ~run_d1_q & ctrl_en_q;
    assign index_rise = s_index & ~index_d1_q;

    // Sequencer state and its latches.
    drive_ctl_pkg::seq_e state_q;
    drive_ctl_pkg::seq_e state_d;
    logic       mode_run_q, run_flop_q, skip_q, speed_ok_q, speed_lock_q;
    logic       spin_on_q, sweep_done_q, left_home_q, withdraw_q, parked_q;
    logic       fault_any;
    logic [7:0] wait_cnt_q;

    // Next state of the start-up sequence.
    always_comb begin
        state_d = state_q;
        case (state_q)
            drive_ctl_pkg::ST_LOAD:   if (mode_run_q) begin
                state_d = drive_ctl_pkg::ST_RUN;
            end
            drive_ctl_pkg::ST_RUN:    state_d = drive_ctl_pkg::ST_CART;
            drive_ctl_pkg::ST_CART:   if (s_cart) begin
                state_d = drive_ctl_pkg::ST_SPIN;
            end
            drive_ctl_pkg::ST_SPIN:
                if (parked_q && sweep_done_q && speed_ok_q) begin
                    state_d = drive_ctl_pkg::ST_SEEK;
                end
            drive_ctl_pkg::ST_SEEK:   state_d = drive_ctl_pkg::ST_TRACKS;
            drive_ctl_pkg::ST_TRACKS: if (s_tracks) begin
                state_d = drive_ctl_pkg::ST_READY;
            end
            drive_ctl_pkg::ST_READY:  state_d = drive_ctl_pkg::ST_READY;
            default:                  state_d = drive_ctl_pkg::ST_LOAD;
        endcase
        if (!s_run) begin
            state_d = drive_ctl_pkg::ST_LOAD;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= drive_ctl_pkg::ST_LOAD;
        end else begin
            state_q <= state_d;
        end
    end

    // Mode latch goes to Run on the switch edge while enabled, back on Load.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_run_q <= 1'b0;
        end else if (!s_run) begin
            mode_run_q <= 1'b0;
        end else if (go_run) begin
            mode_run_q <= 1'b1;
        end
    end

    // Run flop and delay bypass latch; emergency withdraw drops bypass.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_flop_q <= 1'b0;
            skip_q     <= 1'b0;
        end else if (!s_run) begin
            run_flop_q <= 1'b0;
            skip_q     <= 1'b0;
        end else if (state_q == drive_ctl_pkg::ST_RUN) begin
            run_flop_q <= 1'b1;
            skip_q     <= ~ctrl_noskip_q;
        end else if (s_emerg) begin
            skip_q     <= 1'b0;
        end
    end

    // Start-up wait counter, stepped by the lower disk index.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_cnt_q <= '0;
        end else if (state_q == drive_ctl_pkg::ST_RUN) begin
            wait_cnt_q <= '0;
        end else if (index_rise && wait_cnt_q != drive_ctl_pkg::DELAY_REVS)
        begin
            wait_cnt_q <= wait_cnt_q + 8'h01;
        end
    end

    // Speed flag; held clear after an emergency withdraw until Load.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            speed_ok_q   <= 1'b0;
            speed_lock_q <= 1'b0;
        end else begin
            if (s_emerg) begin
                speed_lock_q <= 1'b1;
            end else if (!s_run) begin
                speed_lock_q <= 1'b0;
            end
            speed_ok_q <= s_speed & run_flop_q & ~speed_lock_q & ~s_emerg
                & (skip_q | wait_cnt_q == drive_ctl_pkg::DELAY_REVS);
        end
    end

    // Spindle-on and sweep-done latches, brush park tracking.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            spin_on_q    <= 1'b0;
            sweep_done_q <= 1'b1;
            left_home_q  <= 1'b0;
            parked_q     <= 1'b1;
        end else begin
            parked_q <= ~s_away;
            if (!s_run) begin
                spin_on_q <= 1'b0;
            end else if (state_q == drive_ctl_pkg::ST_CART && s_cart) begin
                spin_on_q    <= 1'b1;
                sweep_done_q <= 1'b0;
                left_home_q  <= 1'b0;
            end else if (!sweep_done_q) begin
                if (!parked_q) begin
                    left_home_q <= 1'b1;
                end else if (left_home_q) begin
                    sweep_done_q <= 1'b1;
                end
            end
        end
    end

    // Withdraw latch: released on heads load, set again on Load or alarm.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            withdraw_q <= 1'b1;
        end else if (!s_run || s_emerg) begin
            withdraw_q <= 1'b1;
        end else if (state_q == drive_ctl_pkg::ST_SPIN &&
                     state_d == drive_ctl_pkg::ST_SEEK) begin
            withdraw_q <= 1'b0;
        end
    end

    // Fault causes seen this cycle.
    logic [drive_ctl_pkg::FLT_W-1:0] flt_now;
    always_comb begin
        flt_now = '0;
        flt_now[drive_ctl_pkg::FLT_WR_NO_GATE] = (s_ac | s_dc) & ~s_wgate;
        flt_now[drive_ctl_pkg::FLT_NO_AC]      = s_wgate & ~s_ac;
        flt_now[drive_ctl_pkg::FLT_NO_DC]      = s_wgate & ~s_dc;
        flt_now[drive_ctl_pkg::FLT_ER_NO_CMD]  = s_ecur & ~s_ecmd;
        flt_now[drive_ctl_pkg::FLT_NO_ERASE]   = s_ecmd & ~s_ecur;
        flt_now[drive_ctl_pkg::FLT_MULTI_HEAD] = ones4(s_heads) > 3'h1;
        flt_now[drive_ctl_pkg::FLT_OPEN_COIL]  = s_open;
    end

    // AHB-Lite address phase capture.
    logic       wr_pend_q, take;
    logic [7:0] wr_addr_q, a_ofs;
    assign take  = hsel & hready & htrans[1];
    assign a_ofs = haddr[7:0];

    logic fault_wr;
    assign fault_wr = wr_pend_q && wr_addr_q == drive_ctl_pkg::FAULT_OFS;

    // Sticky fault causes; a new fault wins over a write-one clear.
    logic [drive_ctl_pkg::FLT_W-1:0] faults_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            faults_q <= '0;
        end else begin
            faults_q <= (faults_q & ~(fault_wr ?
                hwdata[drive_ctl_pkg::FLT_W-1:0] : '0)) | flt_now;
        end
    end
    assign fault_any = |faults_q;

    // Control register write.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {ctrl_noskip_q, ctrl_en_q} <= drive_ctl_pkg::CTRL_RESET;
        end else if (wr_pend_q && wr_addr_q == drive_ctl_pkg::CTRL_OFS) begin
            ctrl_en_q     <= hwdata[drive_ctl_pkg::CTRL_EN_BIT];
            ctrl_noskip_q <= hwdata[drive_ctl_pkg::CTRL_NOSKIP_BIT];
        end
    end

    // Read data is registered so it stands in the data phase.
    logic [31:0] rd_d;
    always_comb begin
        case (a_ofs)
            drive_ctl_pkg::CTRL_OFS:   rd_d = {30'h0, ctrl_noskip_q,
                                               ctrl_en_q};
            drive_ctl_pkg::STATUS_OFS: rd_d = {20'h0, fault_any, skip_q,
                                               speed_ok_q, parked_q,
                                               sweep_done_q, state_q};
            drive_ctl_pkg::FAULT_OFS:  rd_d = {25'h0, faults_q};
            drive_ctl_pkg::COUNT_OFS:  rd_d = {24'h0, wait_cnt_q};
            default:                   rd_d = 32'h0;
        endcase
    end

    // Bus pipeline: write address capture, read data and ready.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            hrdata    <= '0;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            wr_pend_q <= take & hwrite;
            wr_addr_q <= a_ofs;
            hrdata    <= (take & ~hwrite) ? rd_d : 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Drive, ready and fault outputs, each from a flip-flop.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase1_en         <= 1'b0;
            phase2_en         <= 1'b0;
            brush_enable      <= 1'b0;
            cartridge_release <= 1'b1;
            initialize        <= 1'b1;
            head_withdraw     <= 1'b1;
            positioner_free   <= 1'b1;
            seek_zero         <= 1'b0;
            brushes_parked    <= 1'b1;
            ready             <= 1'b0;
            ready_lamp        <= 1'b0;
            write_fault_n     <= 1'b1;
            check_lamp        <= 1'b0;
            write_protect     <= 1'b0;
        end else begin
            phase1_en         <= spin_on_q;
            phase2_en         <= spin_on_q;
            brush_enable      <= spin_on_q & ~sweep_done_q;
            cartridge_release <= ~spin_on_q;
            initialize        <= ~spin_on_q;
            head_withdraw     <= withdraw_q;
            positioner_free   <= withdraw_q;
            seek_zero         <= state_q == drive_ctl_pkg::ST_SEEK;
            brushes_parked    <= parked_q;
            ready      <= state_q == drive_ctl_pkg::ST_READY;
            ready_lamp <= state_q == drive_ctl_pkg::ST_READY
                          & ~fault_any;
            write_fault_n <= ~fault_any;
            check_lamp    <= fault_any;
            write_protect <= fault_any;
        end
    end
endmodule
`default_nettype wire

// ### verification/drive_ctl_props.sv
// Concurrent checks on the drive start-up and fault control ports.
`default_nettype none
module drive_ctl_props (
    input wire logic       hclk,                 // Clock.
    input wire logic       hresetn,              // Reset, low.
    input wire logic       cart_present,         // Cartridge in.
    input wire logic       brush_home,           // Brush sensor.
    input wire logic       heads_over_data_area, // Heads on tracks.
    input wire logic       write_gate_n,         // Write enable, low.
    input wire logic       wr_cur_ac,            // AC write current.
    input wire logic [3:0] head_sel,             // Head selects.
    input wire logic       phase1_en,            // Spindle phase 1.
    input wire logic       phase2_en,            // Spindle phase 2.
    input wire logic       brush_enable,         // Brush motor.
    input wire logic       cartridge_release,    // Cartridge unlock.
    input wire logic       initialize,           // Initialize line.
    input wire logic       head_withdraw,        // Heads retracted.
    input wire logic       positioner_free,      // Positioner free.
    input wire logic       seek_zero,            // Seek cylinder zero.
    input wire logic       brushes_parked,       // Brushes home.
    input wire logic       ready,                // Drive ready.
    input wire logic       ready_lamp,           // Ready lamp.
    input wire logic       write_fault_n,        // Write check, low.
    input wire logic       check_lamp,           // Check lamp.
    input wire logic       write_protect         // Protect forced.
);
    timeunit 1ns;
    timeprecision 1ps;
    // All checks share the one clock and its reset.
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence rel_s; $fell(head_withdraw); endsequence
    sequence seek_s; ##[0:3] seek_zero; endsequence

    spin_out_a: assert property (
        $rose(phase1_en) |-> phase2_en && brush_enable
        ##[0:2] (!cartridge_release && !initialize))
        else $error("spindle start outputs wrong");
    no_cart_a: assert property (
        !cart_present [*8] |-> !$rose(phase1_en))
        else $error("spindle started without cartridge");
    load_rel_a: assert property (
        rel_s |-> !positioner_free && brushes_parked && !brush_enable)
        else $error("heads released too early");
    seek_after_a: assert property (rel_s |-> seek_s)
        else $error("no seek after release");
    park_follow_a: assert property (
        (brush_enable && !brush_home) [*6] |-> !brushes_parked)
        else $error("parked flag stuck during sweep");
    sweep_end_a: assert property (
        $rose(brushes_parked) && phase1_en |-> ##[0:3] !brush_enable)
        else $error("brush motor kept running");
    ready_cause_a: assert property (
        $rose(ready) |-> heads_over_data_area && !head_withdraw)
        else $error("ready without heads on tracks");
    fault_resp_a: assert property (
        !write_fault_n |-> check_lamp && write_protect && !ready_lamp)
        else $error("fault response incomplete");
    stray_write_a: assert property (
        (write_gate_n && wr_cur_ac) [*3] |-> ##[0:4] !write_fault_n)
        else $error("stray write current missed");
    multi_head_a: assert property (
        ($countones(head_sel) > 1) [*3] |-> ##[0:4] !write_fault_n)
        else $error("multiple heads missed");
endmodule
bind drive_ctl drive_ctl_props props_u (.hclk, .hresetn, .cart_present,
    .brush_home, .heads_over_data_area, .write_gate_n, .wr_cur_ac,
    .head_sel, .phase1_en, .phase2_en, .brush_enable, .cartridge_release,
    .initialize, .head_withdraw, .positioner_free, .seek_zero,
    .brushes_parked, .ready, .ready_lamp, .write_fault_n, .check_lamp,
    .write_protect);
`default_nettype wire

// ### verification/host_ctl_model.sv
// Behavioural host controller and head current loop for the drive.
`default_nettype none
module host_ctl_model (
    input  wire logic       wr_req,       // Host writes.
    input  wire logic       er_req,       // Host erases.
    input  wire logic [4:0] bad,          // Current faults to inject.
    output logic            write_gate_n, // Write enable, low.
    output logic            erase_cmd,    // Erase request.
    output logic            wr_cur_ac,    // AC write current.
    output logic            wr_cur_dc,    // DC write current.
    output logic            erase_cur     // Erase current.
);
    timeunit 1ns;
    timeprecision 1ps;
    // Gate is low only while writing; currents follow unless broken.
    assign write_gate_n = !wr_req;
    assign erase_cmd    = er_req;
    assign wr_cur_ac    = (wr_req && !bad[1]) || bad[0];
    assign wr_cur_dc    = (wr_req && !bad[2]) || bad[0];
    assign erase_cur    = (er_req && !bad[4]) || bad[3];
endmodule
`default_nettype wire

// ### verification/tb_drive_ctl.sv
// Self-checking bench for the drive start-up and fault control block.
`default_nettype none
module tb_drive_ctl;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic        run_switch, cart_present, brush_home, speed_sense;
    logic        emerg_withdraw, heads_over_data_area, bottom_disk_index;
    logic        write_gate_n, erase_cmd, wr_cur_ac, wr_cur_dc, erase_cur;
    logic [3:0]  head_sel;
    logic [4:0]  bad;
    logic        coil_open, wr_req, er_req, seek_seen;
    logic        phase1_en, phase2_en, brush_enable, cartridge_release;
    logic        initialize, head_withdraw, positioner_free, seek_zero;
    logic        brushes_parked, ready, ready_lamp, write_fault_n;
    logic        check_lamp, write_protect;
    logic [11:0] flt_tab [7];
    int          error_cnt, checks, k;

    drive_ctl dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .run_switch, .cart_present, .brush_home, .speed_sense,
        .emerg_withdraw, .heads_over_data_area, .bottom_disk_index,
        .write_gate_n, .erase_cmd, .wr_cur_ac, .wr_cur_dc, .erase_cur,
        .head_sel, .coil_open, .phase1_en, .phase2_en, .brush_enable,
        .cartridge_release, .initialize, .head_withdraw, .positioner_free,
        .seek_zero, .brushes_parked, .ready, .ready_lamp, .write_fault_n,
        .check_lamp, .write_protect);
    host_ctl_model host_u (.wr_req, .er_req, .bad, .write_gate_n,
        .erase_cmd, .wr_cur_ac, .wr_cur_dc, .erase_cur);

    // Clock, seek pulse catcher and hang watchdog.
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    always @(posedge hclk) if (seek_zero === 1'b1) seek_seen <= 1'b1;
    initial begin
        repeat (20000) @(posedge hclk);
        error_cnt++;
        $display("unexpected at %0t: watchdog expired", $time);
        final_report();
    end

    task chk_bit(input logic got, input logic exp, input string m);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task chk_word(input logic [31:0] got, input logic [31:0] exp,
                  input string m);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h", $time, m, got);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic wait_lvl(ref logic s, input logic v);
        for (int j = 0; j < 64 && s !== v; j++) @(posedge hclk);
    endtask
    task ahb_wr(input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task ahb_rd(input logic [7:0] a, output logic [31:0] d);
        hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= 1'b0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask
    task idx(input int n);
        repeat (n) begin
            bottom_disk_index <= 1'b1;
            wt(4);
            bottom_disk_index <= 1'b0;
            wt(4);
        end
    endtask
    task final_report;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Main sequence: reset, start-up, faults, withdraw and index count.
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, run_switch, cart_present} = 0;
        {speed_sense, emerg_withdraw, heads_over_data_area} = 0;
        {bottom_disk_index, coil_open, wr_req, er_req, bad} = 0;
        {hresetn, seek_seen, error_cnt, checks} = 0;
        brush_home = 1'b1;
        head_sel = 4'h1;
        flt_tab = '{12'b0000001_0001_0, 12'b1000010_0001_0,
                    12'b1000100_0001_0, 12'b0001000_0001_0,
                    12'b0110000_0001_0, 12'b0000000_0011_0,
                    12'b0000000_0001_1};
        wt(20);
        hresetn <= 1'b1;
        wt(1);
        chk_word({head_withdraw, positioner_free, cartridge_release,
            initialize, phase1_en, write_fault_n, ready}, 32'h7a, "rst");
        ahb_rd(drive_ctl_pkg::CTRL_OFS, rd);
        chk_word(rd, 32'(drive_ctl_pkg::CTRL_RESET), "ctrl reset");
        ahb_wr(drive_ctl_pkg::STATUS_OFS, 32'hffffffff);
        ahb_rd(drive_ctl_pkg::STATUS_OFS, rd);
        chk_word(rd[6:0], drive_ctl_pkg::ST_LOAD, "status write");
        ahb_rd(8'h10, rd);
        chk_word(rd, 32'h0, "unmapped read");
        chk_bit(hresp, 1'b0, "error response");
        run_switch <= 1'b1;
        wt(20);
        chk_bit(phase1_en, 1'b0, "spun without cartridge");
        ahb_rd(drive_ctl_pkg::STATUS_OFS, rd);
        chk_word(rd[6:0], drive_ctl_pkg::ST_CART, "cart wait");
        chk_bit(rd[10], 1'b1, "bypass latch");
        cart_present <= 1'b1;
        wait_lvl(phase1_en, 1'b1);
        wt(2);
        chk_word({phase1_en, phase2_en, brush_enable, cartridge_release,
            initialize}, 32'h1c, "spin outputs");
        brush_home <= 1'b0;
        wait_lvl(brushes_parked, 1'b0);
        ahb_rd(drive_ctl_pkg::STATUS_OFS, rd);
        chk_word(rd[8:7], 32'h0, "sweep leave");
        chk_bit(brush_enable, 1'b1, "brush stopped early");
        brush_home <= 1'b1;
        wait_lvl(brush_enable, 1'b0);
        chk_bit(brushes_parked, 1'b1, "brush return");
        wt(10);
        chk_bit(head_withdraw, 1'b1, "loaded below speed");
        speed_sense <= 1'b1;
        wait_lvl(head_withdraw, 1'b0);
        wt(4);
        chk_word({head_withdraw, positioner_free}, 32'h0, "load");
        chk_bit(seek_seen, 1'b1, "no seek to zero");
        chk_bit(ready, 1'b0, "early ready");
        heads_over_data_area <= 1'b1;
        wait_lvl(ready, 1'b1);
        wt(1);
        chk_word({ready, ready_lamp}, 32'h3, "ready");
        {wr_req, er_req} <= 2'h3;
        wt(10);
        chk_bit(write_fault_n, 1'b1, "healthy write");
        for (k = 0; k < 7; k++) begin
            {wr_req, er_req, bad, head_sel, coil_open} <= flt_tab[k];
            wait_lvl(write_fault_n, 1'b0);
            wt(1);
            chk_word({write_fault_n, check_lamp, write_protect, ready_lamp,
                ready}, 32'h0d, "fault response");
            {wr_req, er_req, bad, head_sel, coil_open} <= 12'h002;
            ahb_rd(drive_ctl_pkg::FAULT_OFS, rd);
            chk_word(rd & 32'h7f, 32'h1 << k, "cause");
            wt(4);
            ahb_wr(drive_ctl_pkg::FAULT_OFS, 32'h7f);
            wait_lvl(write_fault_n, 1'b1);
            chk_bit(write_fault_n, 1'b1, "fault not cleared");
        end
        emerg_withdraw <= 1'b1;
        wait_lvl(head_withdraw, 1'b1);
        emerg_withdraw <= 1'b0;
        wt(8);
        ahb_rd(drive_ctl_pkg::STATUS_OFS, rd);
        chk_word(rd[9], 32'h0, "speed after withdraw");
        run_switch <= 1'b0;
        ahb_wr(drive_ctl_pkg::CTRL_OFS, 32'h2);
        run_switch <= 1'b1;
        wt(10);
        ahb_rd(drive_ctl_pkg::STATUS_OFS, rd);
        chk_word(rd[6:0], drive_ctl_pkg::ST_LOAD, "run while disabled");
        run_switch <= 1'b0;
        wt(8);
        ahb_wr(drive_ctl_pkg::CTRL_OFS, 32'h3);
        run_switch <= 1'b1;
        wt(10);
        idx(15);
        ahb_rd(drive_ctl_pkg::STATUS_OFS, rd);
        chk_word(rd[10:9], 32'h0, "speed before count");
        idx(1);
        ahb_rd(drive_ctl_pkg::COUNT_OFS, rd);
        chk_word(rd, 32'(drive_ctl_pkg::DELAY_REVS), "count");
        ahb_rd(drive_ctl_pkg::STATUS_OFS, rd);
        chk_bit(rd[9], 1'b1, "speed after count");
        final_report();
    end
endmodule
`default_nettype wire
